/* File: design/dpbs_pkg.sv */
// Constants, pin carriers and write records for the burst SRAM core.
// Functional notes
// - Read data pins only read, write data pins only write; no turnaround.
// - One shared address bus; read and write addresses on alternate K rises.
// - Each address holds two 36-bit words moved as a two-word burst.
// - Data words move on every K rise and every K-bar rise.
// - Inputs are registered by K or K-bar; only rising edges act.
// - Read data leaves from output registers clocked by K or K-bar.
// - Accepted writes finish into the array by internal self-timed logic.
// - With pll_bypass high, read data follows the read address by 2 cycles.
// - With pll_bypass low, read data follows the read address by 1 cycle.
// - Each port has its own select; ports work independently.
// - The read_valid_flag output marks valid read data on the pins.
// - A complementary echo_clock pair travels with the read data.
// - A read returns the newest written data, even if not yet committed.
package dpbs_pkg;

  localparam int WORD_W = 36;
  localparam int ADDR_W = 20;
  localparam int FIFO_DEPTH = 4;

  // Read latency in K periods, picked by the pll_bypass pin.
  localparam logic [1:0] LAT_PLL = 2'h2;
  localparam logic [1:0] LAT_BYPASS = 2'h1;

  // The slot toggles on every accepted K rise; reset opens a read slot.
  localparam logic SLOT_READ = 1'h0;
  localparam logic SLOT_WRITE = 1'h1;
  localparam logic RST_SLOT = SLOT_READ;
  localparam logic [1:0] RST_CNT = 2'h0;

  // K-bar idles high while K idles low, so its sampler starts high too.
  // Starting it low would show a false K-bar rise just after reset.
  localparam logic RST_KN = 1'h1;

  typedef struct packed {
    logic k;
    logic k_n;
    logic bypass;
    logic rd_sel_n;
    logic wr_sel_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] d;
  } dpbs_pin_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] w0;
  } dpbs_wr_s;

  localparam int WR_W = $bits(dpbs_wr_s);

endpackage

/* File: design/dpbs_core.sv */
// Two-port double data rate burst SRAM core with its write FIFO.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module dpbs_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  output logic [D-1:0][W-1:0] o_age,
  output logic [D-1:0] o_age_vld
);

  // Pointers wrap naturally, so D must be a power of two.
  localparam int PW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] cnt;
  } dpbs_fifo_s;

  dpbs_fifo_s st;
  dpbs_fifo_s next_st;
  logic push;
  logic pop;

  assign o_in_ready = (st.cnt != (PW+1)'(D));
  assign o_out_valid = (st.cnt != '0);
  assign o_out_data = st.mem[st.rd];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Entries are presented oldest first so the reader can let newer win.
  always_comb begin
    for (int i = 0; i < D; i++) begin
      o_age[i] = st.mem[st.rd + PW'(i)];
      o_age_vld[i] = (PW+1)'(i) < st.cnt;
    end
  end

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = i_in_data;
      next_st.wr = st.wr + PW'(1);
    end
    if (pop) begin
      next_st.rd = st.rd + PW'(1);
    end
    next_st.cnt = st.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////
module dpbs_core (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_k,
  input wire logic i_clk_k_n,
  input wire logic i_pll_bypass,
  input wire logic i_read_sel_n,
  input wire logic i_write_sel_n,
  input wire logic [dpbs_pkg::ADDR_W-1:0] i_addr,
  input wire logic [dpbs_pkg::WORD_W-1:0] i_wdata,
  output logic [dpbs_pkg::WORD_W-1:0] o_rdata,
  output logic o_read_valid_flag,
  output logic o_echo_clock,
  output logic o_echo_clock_n
);

  localparam int AW = dpbs_pkg::ADDR_W;
  localparam int WW = dpbs_pkg::WORD_W;
  localparam int DEP = dpbs_pkg::FIFO_DEPTH;

  typedef struct packed {
    dpbs_pkg::dpbs_pin_s s1;
    dpbs_pkg::dpbs_pin_s s2;
    dpbs_pkg::dpbs_pin_s s3;
    logic k_st;
    logic kn_st;
    logic byp;
    logic slot;
    logic wr_exp;
    dpbs_pkg::dpbs_wr_s wr_cap;
    logic pend_vld;
    dpbs_pkg::dpbs_wr_s pend;
    logic wr_seen;
    logic q_vld;
    logic [1:0] q_cnt;
    logic [2*WW-1:0] q_data;
    logic w1_due;
    logic [WW-1:0] w1_hold;
    logic [WW-1:0] rdata;
    logic rvalid;
  } dpbs_core_s;

  dpbs_core_s st;
  dpbs_core_s next_st;

  // The array itself cannot live in the state record.
  logic [2*WW-1:0] mem [2**AW];

  dpbs_pkg::dpbs_pin_s pins;
  logic k_rise;
  logic kn_rise;
  logic rd_now;
  logic wr_now;
  logic [1:0] lat;
  logic [2*WW-1:0] look;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  dpbs_pkg::dpbs_wr_s f_out;
  logic [DEP-1:0][dpbs_pkg::WR_W-1:0] f_age;
  logic [DEP-1:0] f_age_vld;
  logic drain;

  assign pins = '{
    k: i_clk_k,
    k_n: i_clk_k_n,
    bypass: i_pll_bypass,
    rd_sel_n: i_read_sel_n,
    wr_sel_n: i_write_sel_n,
    addr: i_addr,
    d: i_wdata
  };

  //////////////////////////////////////////////////////////////////////////
  // Edge finding on the sampled link clocks.

  // An edge counts only once stages two and three agree, which also
  // lets the address and data pins settle before they are used.
  assign k_rise = st.s2.k && st.s3.k && !st.k_st;
  assign kn_rise = st.s2.k_n && st.s3.k_n && !st.kn_st;

  assign lat = st.byp ? dpbs_pkg::LAT_PLL : dpbs_pkg::LAT_BYPASS;

  assign rd_now = k_rise && (st.slot == dpbs_pkg::SLOT_READ)
    && !st.s3.rd_sel_n;
  assign wr_now = k_rise && (st.slot == dpbs_pkg::SLOT_WRITE)
    && !st.s3.wr_sel_n;

  //////////////////////////////////////////////////////////////////////////
  // Coherent lookup: array, then FIFO oldest to newest, then the pending
  // record, so the last match is always the most recent write.

  always_comb begin
    dpbs_pkg::dpbs_wr_s e;
    e = '0;
    look = mem[st.s3.addr];
    for (int i = 0; i < DEP; i++) begin
      e = f_age[i];
      if (f_age_vld[i] && e.addr == st.s3.addr) begin
        look = {e.w1, e.w0};
      end
    end
    if (st.pend_vld && st.pend.addr == st.s3.addr) begin
      look = {st.pend.w1, st.pend.w0};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write FIFO between the captured burst and the array.

  dpbs_fifo #(
    .W(dpbs_pkg::WR_W),
    .D(DEP)
  ) u_wfifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(st.pend_vld),
    .o_in_ready(f_in_ready),
    .i_in_data(st.pend),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_out_ready),
    .o_out_data(f_out),
    .o_age(f_age),
    .o_age_vld(f_age_vld)
  );

  // The array has one port; a read lookup takes it and stalls the drain.
  assign f_out_ready = !rd_now;
  assign drain = f_out_valid && f_out_ready;

  always_ff @(posedge i_clk) begin
    if (drain) begin
      mem[f_out.addr] <= {f_out.w1, f_out.w0};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2.k == st.s3.k) begin
      next_st.k_st = st.s3.k;
    end
    if (st.s2.k_n == st.s3.k_n) begin
      next_st.kn_st = st.s3.k_n;
    end
    if (st.s2.bypass == st.s3.bypass) begin
      next_st.byp = st.s3.bypass;
    end

    // A push frees the record; a new burst arriving below wins.
    if (st.pend_vld && f_in_ready) begin
      next_st.pend_vld = 1'b0;
    end

    if (k_rise) begin
      next_st.slot = ~st.slot;
      next_st.w1_due = 1'b0;
      next_st.rvalid = 1'b0;
      if (st.q_vld && st.q_cnt == 2'h1) begin
        next_st.rdata = st.q_data[WW-1:0];
        next_st.w1_hold = st.q_data[2*WW-1:WW];
        next_st.w1_due = 1'b1;
        next_st.rvalid = 1'b1;
        next_st.q_vld = 1'b0;
      end else if (st.q_vld) begin
        next_st.q_cnt = st.q_cnt - 2'h1;
      end
      if (rd_now) begin
        next_st.q_vld = 1'b1;
        next_st.q_cnt = lat;
        next_st.q_data = look;
      end
      if (wr_now) begin
        next_st.wr_exp = 1'b1;
        next_st.wr_cap.addr = st.s3.addr;
        next_st.wr_cap.w0 = st.s3.d;
      end
    end

    if (kn_rise) begin
      if (st.w1_due) begin
        next_st.rdata = st.w1_hold;
        next_st.w1_due = 1'b0;
      end
      if (st.wr_exp) begin
        next_st.wr_exp = 1'b0;
        // A burst that finds the record still full is dropped; at the
        // link rate the FIFO drains far faster than bursts arrive.
        if (!st.pend_vld || f_in_ready) begin
          next_st.pend = '{
            addr: st.wr_cap.addr,
            w1: st.s3.d,
            w0: st.wr_cap.w0
          };
          next_st.pend_vld = 1'b1;
          next_st.wr_seen = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st <= '0;
      st.slot <= dpbs_pkg::RST_SLOT;
      st.q_cnt <= dpbs_pkg::RST_CNT;
      st.s1.k_n <= dpbs_pkg::RST_KN;
      st.s2.k_n <= dpbs_pkg::RST_KN;
      st.s3.k_n <= dpbs_pkg::RST_KN;
      st.kn_st <= dpbs_pkg::RST_KN;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs. Read data has its own pins, never shared with write data.

  assign o_rdata = st.rdata;
  assign o_read_valid_flag = st.rvalid;
  assign o_echo_clock = st.k_st;
  assign o_echo_clock_n = st.kn_st;

  //////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_slot_alternates: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    k_rise |=> st.slot != $past(st.slot)
  ) else $error("slot did not alternate on K rise");

  a_lat_two: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    rd_now && st.byp |=> st.q_vld && st.q_cnt == 2'h2
  ) else $error("latency two not loaded");

  a_lat_one: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    rd_now && !st.byp |=> st.q_vld && st.q_cnt == 2'h1
  ) else $error("latency one not loaded");

  a_valid_at_k: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    $rose(o_read_valid_flag) |-> $past(k_rise) && $past(st.q_cnt) == 2'h1
  ) else $error("valid rose off a K rise");

  a_word_one: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    kn_rise && st.w1_due |=> o_rdata == $past(st.w1_hold)
      && o_read_valid_flag
  ) else $error("second word not driven");

  a_data_edges: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !k_rise && !kn_rise |=> $stable(o_rdata)
  ) else $error("read data moved off a clock edge");

  a_select_gate: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    k_rise && st.s3.rd_sel_n && st.s3.wr_sel_n
      |=> !st.wr_exp && $stable(st.q_data)
  ) else $error("burst started without select");

  a_write_commit: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    drain |=> mem[$past(f_out.addr)] == {$past(f_out.w1), $past(f_out.w0)}
  ) else $error("write not committed to array");

  a_newest_wins: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    rd_now && st.wr_seen && st.pend.addr == st.s3.addr
      |=> st.q_data == {$past(st.pend.w1), $past(st.pend.w0)}
  ) else $error("read missed newest write");

  a_echo_pair: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    st.s2.k && st.s3.k |=> o_echo_clock
  ) else $error("echo clock not following K");

endmodule

/* File: tb/dpbs_ctrl_model.sv */
// Memory controller model: free-running K pair, selects, address, data.
`timescale 1ns/1ns
module dpbs_ctrl_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  output logic o_clk_k,
  output logic o_clk_k_n,
  output logic o_read_sel_n,
  output logic o_write_sel_n,
  output logic [dpbs_pkg::ADDR_W-1:0] o_addr,
  output logic [dpbs_pkg::WORD_W-1:0] o_wdata,
  output logic o_rd_go
);
  // K period is 8 i_clk; pins change midway between K and K-bar rises.
  logic [2:0] ph = 3'h0;
  logic [2:0] pre = 3'h0;
  logic nxt_wr = 1'b0;
  logic rd_req = 1'b0, rd_pend = 1'b0, wr_req = 1'b0, wr_sel = 1'b0;
  logic wr_go = 1'b0;
  logic [dpbs_pkg::ADDR_W-1:0] rd_a = '0, wr_a = '0;
  logic [dpbs_pkg::WORD_W-1:0] w0 = '0, w1 = '0;
  initial begin
    {o_clk_k, o_rd_go, o_addr, o_wdata} = '0;
    o_clk_k_n = 1'b1;
    {o_read_sel_n, o_write_sel_n} = 2'h3;
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    o_rd_go <= 1'b0;
    if (!i_reset_n) begin
      {pre, ph, nxt_wr, o_clk_k} <= '0;
      o_clk_k_n <= 1'b1;
    end else if (pre != 3'h4) begin
      pre <= pre + 3'h1;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) begin
        {o_clk_k, o_clk_k_n} <= 2'h2;
        nxt_wr <= ~nxt_wr;
        o_rd_go <= rd_pend;
        rd_pend <= 1'b0;
      end
      if (ph == 3'h3) begin
        {o_clk_k, o_clk_k_n} <= 2'h1;
      end
      if (ph == 3'h1 && wr_go) begin
        o_wdata <= w1;
        wr_go <= 1'b0;
      end
      // Idle pins get inverted values so stale data never looks valid.
      if (ph == 3'h5 && nxt_wr) begin
        o_write_sel_n <= !(wr_req && wr_sel);
        o_read_sel_n <= 1'b1;
        o_addr <= wr_req ? wr_a : ~o_addr;
        o_wdata <= wr_req ? w0 : ~o_wdata;
        wr_go <= wr_req;
        if (wr_req) wr_req <= 1'b0;
      end else if (ph == 3'h5) begin
        o_read_sel_n <= !rd_req;
        o_write_sel_n <= 1'b1;
        o_addr <= rd_req ? rd_a : ~o_addr;
        o_wdata <= ~o_wdata;
        rd_pend <= rd_req;
        if (rd_req) rd_req <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic post_read(input logic [dpbs_pkg::ADDR_W-1:0] ad);
    rd_a <= ad;
    rd_req <= 1'b1;
    @(posedge i_clk);
    while (rd_req) @(posedge i_clk);
  endtask
  task automatic post_write(input logic [dpbs_pkg::ADDR_W-1:0] ad,
                            input logic [dpbs_pkg::WORD_W-1:0] d0, d1,
                            input logic sel);
    {wr_a, w0, w1, wr_sel} <= {ad, d0, d1, sel};
    wr_req <= 1'b1;
    @(posedge i_clk);
    while (wr_req) @(posedge i_clk);
  endtask
endmodule

/* File: tb/dpbs_core_tb_top.sv */
// Self-checking bench for the burst SRAM core with its controller model.
`timescale 1ns/1ns
module dpbs_core_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, byp = 1'b1;
  logic k, kn, rsn, wsn, rv, ec, ecn, go;
  logic [dpbs_pkg::ADDR_W-1:0] a;
  logic [dpbs_pkg::WORD_W-1:0] wd, rd;
  int error_cnt = 0, checks_done = 0;
  always #20 clk = ~clk;
  dpbs_core u_dpbs_core (.i_clk(clk), .i_reset_n(rst_n), .i_clk_k(k),
    .i_clk_k_n(kn), .i_pll_bypass(byp), .i_read_sel_n(rsn),
    .i_write_sel_n(wsn), .i_addr(a), .i_wdata(wd), .o_rdata(rd),
    .o_read_valid_flag(rv), .o_echo_clock(ec), .o_echo_clock_n(ecn));
  dpbs_ctrl_model u_dpbs_ctrl_model (.i_clk(clk), .i_reset_n(rst_n),
    .o_clk_k(k), .o_clk_k_n(kn), .o_read_sel_n(rsn), .o_write_sel_n(wsn),
    .o_addr(a), .o_wdata(wd), .o_rd_go(go));
  ////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [71:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Valid should rise about lat K periods plus the sampler delay later.
  task automatic rd_chk(input logic [19:0] ad, input logic [35:0] e0, e1,
                        input int lat);
    int n;
    n = 0;
    u_dpbs_ctrl_model.post_read(ad);
    while (go !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    n = 0;
    while (rv !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    chk(n >= lat * 8 + 2 && n <= lat * 8 + 6, 1'b1);
    chk(rd, e0);
    repeat (6) tick;
    chk(rd, e1);
    chk(rv, 1'b1);
    repeat (4) tick;
    chk(rv, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_fresh;
    u_dpbs_ctrl_model.post_write(20'h0_0012, 36'h1_2345_6789,
                                 36'h9_8765_4321, 1'b1);
    rd_chk(20'h0_0012, 36'h1_2345_6789, 36'h9_8765_4321, 2);
  endtask
  task automatic t_bypass;
    @(posedge clk) byp <= 1'b0;
    repeat (16) tick;
    rd_chk(20'h0_0012, 36'h1_2345_6789, 36'h9_8765_4321, 1);
    @(posedge clk) byp <= 1'b1;
    repeat (16) tick;
  endtask
  task automatic t_ports;
    u_dpbs_ctrl_model.post_write(20'h0_0012, 36'hF_0000_0000,
                                 36'h0_0000_000F, 1'b0);
    rd_chk(20'h0_0012, 36'h1_2345_6789, 36'h9_8765_4321, 2);
    u_dpbs_ctrl_model.post_write(20'hF_FFFF, 36'hA_AAAA_5555,
                                 36'h5_5555_AAAA, 1'b1);
    rd_chk(20'h0_0012, 36'h1_2345_6789, 36'h9_8765_4321, 2);
    rd_chk(20'hF_FFFF, 36'hA_AAAA_5555, 36'h5_5555_AAAA, 2);
  endtask
  task automatic t_idle;
    int h;
    h = 0;
    repeat (40) begin
      tick;
      if (rv !== 1'b0) h++;
    end
    chk(h, 0);
  endtask
  task automatic t_echo;
    int r, m;
    logic p;
    r = 0;
    m = 0;
    p = ec;
    repeat (64) begin
      tick;
      if (ec === 1'b1 && p === 1'b0) r++;
      if (ecn !== ~ec) m++;
      p = ec;
    end
    chk(r, 8);
    chk(m, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // The tests need about 16 us; the limit leaves ample margin.
  initial begin
    #400000;
    error_cnt++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) tick;
    t_fresh;
    t_bypass;
    t_ports;
    t_idle;
    t_echo;
    end_sim;
  end
endmodule
